// [src/vfw_defines.svh]
// Register indices, field positions, reset values and counts of the window block
`ifndef VFW_DEFINES_SVH
`define VFW_DEFINES_SVH

// Register indices; byte address is four times the index
`define VFW_IDX_FLAG 10'h11f
`define VFW_IDX_FIRST 10'h12a
`define VFW_IDX_LINES_IN 10'h12b
`define VFW_IDX_LINES_OUT 10'h12c
`define VFW_IDX_LEFT 10'h12d
`define VFW_IDX_WIDTH 10'h12e
`define VFW_IDX_NPIX 10'h12f
`define VFW_IDX_QUOTA 10'h157

// Reset values
`define VFW_RST_FIRST 12'h011
`define VFW_RST_LINES_IN 12'h1f4
`define VFW_RST_LINES_OUT 12'h0f0
`define VFW_RST_LEFT 12'h000
`define VFW_RST_WIDTH 12'h280
`define VFW_RST_NPIX 12'h280
`define VFW_RST_QUOTA 12'hbb8

// Field positions in the input line word
`define VFW_BIT_DECIM 9
`define VFW_FSEL_HI 11
`define VFW_FSEL_LO 10

// Counts
`define VFW_FRAME_PERIOD 13'hbb8
`define VFW_LINES_625 9'h138
`define VFW_LINES_525 9'h106
`define VFW_DELAY_MAX 11'h7ff

`endif

// [src/vfw_pkg.sv]
// Types shared by the window block
package vfw_pkg;

	// Field select code, in encoding order
	typedef enum logic [1:0] {
		VFW_FIELD_BOTH,
		VFW_FIELD_EVEN,
		VFW_FIELD_ODD,
		VFW_FIELD_OFF
	} vfw_field_sel_type;

	// One set of window parameters
	typedef struct packed {
		logic [11:0] first;
		logic [11:0] lines_in;
		logic [11:0] lines_out;
		logic [11:0] left;
		logic [11:0] width;
		logic [11:0] npix;
		logic [11:0] quota;
	} vfw_param_type;

	// Whole state of the controller
	typedef struct packed {
		vfw_param_type shadow;
		vfw_param_type live;
		logic line_q;
		logic field_q;
		logic [8:0] line_cnt;
		logic [10:0] pix_cnt;
		logic [8:0] drop_acc;
		logic line_keep;
		logic [12:0] frame_acc;
		logic frame_keep;
		logic field_on;
		logic [10:0] dly_cnt;
		logic dly_armed;
		logic [10:0] flag_pos;
		logic active_flag;
		logic [31:0] prdata;
		logic pslverr;
	} vfw_state_type;

endpackage

// [src/vfw_stream_if.sv]
// Pixel stream carrier between the controller and its buffer
`timescale 1ns/1ps
interface vfw_stream_if #(parameter int W = 16);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport buffer(input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data);
	modport user(output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data);
endinterface

// [src/vfw_fifo.sv]
// Small synchronous FIFO for the window pixel stream
`timescale 1ns/1ps
module vfw_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 4
)(
	input wire logic pclk,
	input wire logic presetn,
	vfw_stream_if.buffer s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} vfw_fifo_state_type;

	vfw_fifo_state_type st;
	vfw_fifo_state_type next_st;
	logic push;
	logic pop;

	// Honest flags straight from the count
	assign s.in_ready = (st.cnt != CW'(DEPTH));
	assign s.out_valid = (st.cnt != '0);
	assign s.out_data = st.mem[st.rd];
	assign push = s.in_valid && s.in_ready;
	assign pop = s.out_valid && s.out_ready;

	// Pointer and count update
	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wr] = s.in_data;
			next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + AW'(1);
		end
		if (pop)
			next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + AW'(1);
		if (push && !pop)
			next_st.cnt = st.cnt + CW'(1);
		else if (pop && !push)
			next_st.cnt = st.cnt - CW'(1);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_fifo_no_overrun: assert property (st.cnt <= CW'(DEPTH))
		else $error("fifo count above depth");
endmodule

// [src/vfw_ctrl.sv]
// Video field window controller with APB registers and output buffer
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "vfw_defines.svh"
module vfw_ctrl #(
	parameter int DATA_W = 16,
	parameter int FIFO_DEPTH = 4
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_reference,
	input wire logic field_reference,
	input wire logic field_odd,
	input wire logic std_625,
	input wire logic pix_valid,
	input wire logic [DATA_W-1:0] pix_data,
	output logic pix_ready,
	output logic win_valid,
	output logic [DATA_W-1:0] win_data,
	input wire logic win_ready,
	output logic active_flag
);
	vfw_pkg::vfw_state_type st;
	vfw_pkg::vfw_state_type next_st;
	vfw_pkg::vfw_field_sel_type fsel;
	vfw_stream_if #(.W(DATA_W)) strm();

	logic [9:0] idx;
	logic setup;
	logic wr;
	logic wo_hit;
	logic field_start;
	logic line_rise;
	logic line_fall;
	logic [8:0] total;
	logic [8:0] first9;
	logic [8:0] room;
	logic [8:0] eff_in;
	logic [8:0] line_next;
	logic in_range;
	logic [9:0] drop_sum;
	logic keep_line;
	logic cur_keep;
	logic [10:0] cur_pix;
	logic [11:0] win_end;
	logic pix_in;
	logic take;
	logic push;
	logic [12:0] frame_sum;
	logic frame_next;
	logic gate_next;

	// Output buffer; its fullness stalls the pixel source
	vfw_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.s(strm.buffer)
	);

	assign strm.in_valid = push;
	assign strm.in_data = pix_data;
	assign strm.out_ready = win_ready;
	assign win_valid = strm.out_valid;
	assign win_data = strm.out_data;
	assign pix_ready = strm.in_ready;

	// Bus decode; one wait-free access phase
	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign wo_hit = (idx >= `VFW_IDX_FIRST) && (idx <= `VFW_IDX_NPIX);
	assign pready = psel && penable;
	assign prdata = st.prdata;
	assign pslverr = st.pslverr;
	assign active_flag = st.active_flag;

	// Edges of the video references
	assign field_start = field_reference && !st.field_q;
	assign line_rise = line_reference && !st.line_q;
	assign line_fall = !line_reference && st.line_q;

	// Effective vertical range, clamped to the field total
	assign total = std_625 ? `VFW_LINES_625 : `VFW_LINES_525;
	assign first9 = st.live.first[8:0];
	assign room = (first9 >= total) ? 9'h000 : total - first9;
	assign eff_in = (st.live.lines_in[8:0] > room) ? room : st.live.lines_in[8:0];
	assign line_next = st.line_cnt + 9'h001;
	assign in_range = (line_next >= first9)
		&& ({1'b0, line_next} < {1'b0, first9} + {1'b0, eff_in});

	// Line dropping spreads the kept lines evenly over the range
	assign drop_sum = {1'b0, st.drop_acc} + {1'b0, st.live.lines_out[8:0]};
	assign keep_line = in_range && (drop_sum >= {1'b0, eff_in});

	// A pixel in the rise cycle already belongs to the new line
	assign cur_keep = line_rise ? keep_line : st.line_keep;
	assign cur_pix = line_rise ? 11'h000 : st.pix_cnt;
	assign win_end = {1'b0, st.live.left[10:0]} + {1'b0, st.live.width[10:0]};
	assign pix_in = (cur_pix >= st.live.left[10:0])
		&& ({1'b0, cur_pix} < win_end)
		&& (cur_pix < st.live.npix[10:0]);
	assign take = pix_valid && strm.in_ready && line_reference;
	assign push = take && st.field_on && cur_keep && pix_in;

	// Frame decimation decided once per frame, at the odd field
	assign frame_sum = st.frame_acc + {1'b0, st.shadow.quota};
	always_comb
	begin
		frame_next = st.frame_keep;
		if (field_start && field_odd)
		begin
			if (!st.shadow.lines_in[`VFW_BIT_DECIM])
				frame_next = 1'b1;
			else
				frame_next = (frame_sum >= `VFW_FRAME_PERIOD);
		end
	end

	// Field select gate for the coming field
	assign fsel = vfw_pkg::vfw_field_sel_type'(
		st.shadow.lines_in[`VFW_FSEL_HI:`VFW_FSEL_LO]);
	always_comb
	begin
		case (fsel)
			vfw_pkg::VFW_FIELD_BOTH: gate_next = 1'b1;
			vfw_pkg::VFW_FIELD_EVEN: gate_next = !field_odd;
			vfw_pkg::VFW_FIELD_ODD: gate_next = field_odd;
			default: gate_next = 1'b0;
		endcase
	end

	// Next state of the whole controller
	always_comb
	begin
		next_st = st;
		next_st.line_q = line_reference;
		next_st.field_q = field_reference;
		next_st.active_flag = push;
		// Answer is prepared in setup so data leaves a flip-flop
		if (setup)
		begin
			next_st.prdata = 32'h0000_0000;
			next_st.pslverr = 1'b0;
			if (idx == `VFW_IDX_FLAG)
			begin
				next_st.prdata[11:1] = st.flag_pos;
				next_st.pslverr = pwrite;
			end
			else if (idx == `VFW_IDX_QUOTA)
				next_st.prdata[11:0] = st.shadow.quota;
			else if (!wo_hit)
				next_st.pslverr = 1'b1;
		end
		// Writes land in the shadow set only
		if (wr)
		begin
			if (idx == `VFW_IDX_FIRST)
				next_st.shadow.first = pwdata[11:0];
			else if (idx == `VFW_IDX_LINES_IN)
				next_st.shadow.lines_in = pwdata[11:0];
			else if (idx == `VFW_IDX_LINES_OUT)
				next_st.shadow.lines_out = pwdata[11:0];
			else if (idx == `VFW_IDX_LEFT)
				next_st.shadow.left = pwdata[11:0];
			else if (idx == `VFW_IDX_WIDTH)
				next_st.shadow.width = pwdata[11:0];
			else if (idx == `VFW_IDX_NPIX)
				next_st.shadow.npix = pwdata[11:0];
			else if (idx == `VFW_IDX_QUOTA)
				next_st.shadow.quota = pwdata[11:0];
		end
		// Field boundary: take over the shadow set and decide the field
		if (field_start)
		begin
			next_st.live = st.shadow;
			next_st.line_cnt = 9'h000;
			next_st.drop_acc = 9'h000;
			next_st.line_keep = 1'b0;
			next_st.frame_keep = frame_next;
			next_st.field_on = frame_next && gate_next;
			if (field_odd && st.shadow.lines_in[`VFW_BIT_DECIM])
				next_st.frame_acc = (frame_sum >= `VFW_FRAME_PERIOD)
					? frame_sum - `VFW_FRAME_PERIOD : frame_sum;
		end
		else if (line_rise)
		begin
			next_st.line_cnt = line_next;
			next_st.line_keep = keep_line;
			if (in_range)
				next_st.drop_acc = keep_line
					? 9'(drop_sum - {1'b0, eff_in}) : drop_sum[8:0];
		end
		// Pixel position within the line
		if (take)
			next_st.pix_cnt = cur_pix + 11'h001;
		else if (line_rise)
			next_st.pix_cnt = 11'h000;
		// Delay from line reference fall to the first window pixel
		if (line_fall)
		begin
			next_st.dly_cnt = 11'h000;
			next_st.dly_armed = 1'b1;
		end
		else
		begin
			if (st.dly_cnt != `VFW_DELAY_MAX)
				next_st.dly_cnt = st.dly_cnt + 11'h001; // Saturates on long blanking
			if (push && st.dly_armed)
			begin
				next_st.flag_pos = st.dly_cnt;
				next_st.dly_armed = 1'b0;
			end
		end
	end

	// State register; parameters come up at documented defaults
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.shadow.first <= `VFW_RST_FIRST;
			st.shadow.lines_in <= `VFW_RST_LINES_IN;
			st.shadow.lines_out <= `VFW_RST_LINES_OUT;
			st.shadow.left <= `VFW_RST_LEFT;
			st.shadow.width <= `VFW_RST_WIDTH;
			st.shadow.npix <= `VFW_RST_NPIX;
			st.shadow.quota <= `VFW_RST_QUOTA;
			st.live.first <= `VFW_RST_FIRST;
			st.live.lines_in <= `VFW_RST_LINES_IN;
			st.live.lines_out <= `VFW_RST_LINES_OUT;
			st.live.left <= `VFW_RST_LEFT;
			st.live.width <= `VFW_RST_WIDTH;
			st.live.npix <= `VFW_RST_NPIX;
			st.live.quota <= `VFW_RST_QUOTA;
		end
		else
			st <= next_st;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Live set moves only at a field start
	a_live_field_only: assert property (!field_start |=> $stable(st.live))
		else $error("window parameters changed inside a field");

	// Field code and decimation decide each field
	a_field_off_gate: assert property (field_start
		&& st.shadow.lines_in[11:10] == 2'b11 |=> !st.field_on)
		else $error("window left on with field code off");
	a_odd_only_gate: assert property (field_start && !field_odd
		&& st.shadow.lines_in[11:10] == 2'b10 |=> !st.field_on)
		else $error("odd-only window open in even field");
	a_even_only_gate: assert property (field_start && field_odd
		&& st.shadow.lines_in[11:10] == 2'b01 |=> !st.field_on)
		else $error("even-only window open in odd field");
	a_both_fields_gate: assert property (field_start && frame_next
		&& st.shadow.lines_in[11:10] == 2'b00 |=> st.field_on)
		else $error("window closed with both fields enabled");
	a_closed_no_push: assert property (!st.field_on |-> !push)
		else $error("pixel pushed in a closed field");
	a_decim_off_keep: assert property (field_start && field_odd
		&& !st.shadow.lines_in[9] |=> st.frame_keep)
		else $error("frame dropped with decimation off");
	a_quota_drop: assert property (field_start && field_odd && st.shadow.lines_in[9]
		&& frame_sum < `VFW_FRAME_PERIOD |=> !st.field_on)
		else $error("frame kept although quota ran out");
	a_quota_keep: assert property (field_start && field_odd && st.shadow.lines_in[9]
		&& frame_sum >= `VFW_FRAME_PERIOD |=> st.frame_keep)
		else $error("frame dropped although quota allowed it");

	// Horizontal window and free buffer room of every pushed pixel
	a_push_left_crop: assert property (push |-> cur_pix >= st.live.left[10:0])
		else $error("pixel left of window start pushed");
	a_push_width: assert property (push |-> {1'b0, cur_pix} < win_end)
		else $error("pixel beyond window length pushed");
	a_push_npix: assert property (push |-> cur_pix < st.live.npix[10:0])
		else $error("pixel beyond scaled line pushed");
	a_full_no_push: assert property (!pix_ready |-> !push)
		else $error("pixel pushed into a full buffer");

	// Vertical window and compression
	a_line_clamp: assert property (line_rise && !field_start && keep_line
		|=> st.line_cnt < total && st.line_cnt >= first9)
		else $error("kept line outside clamped range");
	a_range_drop: assert property (line_rise && !field_start && !in_range
		|=> !st.line_keep)
		else $error("line outside clamped range kept");
	a_drop_no_gain: assert property (line_rise && !field_start
		&& st.live.lines_out[8:0] == 9'h000 |=> !st.line_keep)
		else $error("line kept with zero output lines");
	a_keep_all_lines: assert property (line_rise && !field_start && in_range
		&& st.live.lines_out[8:0] >= eff_in |=> st.line_keep)
		else $error("line dropped without compression");

	// Flag delay capture and its readback
	a_flag_capture: assert property (push && st.dly_armed && !line_fall
		|=> st.flag_pos == $past(st.dly_cnt) && active_flag)
		else $error("active flag delay not captured");
	a_flag_pulse: assert property (active_flag |-> $past(push))
		else $error("active flag without a pushed pixel");
	a_flag_readback: assert property (setup && !pwrite && idx == `VFW_IDX_FLAG
		|=> prdata[11:1] == $past(st.flag_pos) && !prdata[0])
		else $error("flag position read wrong");
	a_flag_write_err: assert property (setup && pwrite && idx == `VFW_IDX_FLAG
		|=> pslverr)
		else $error("write to flag position not refused");

	// Bus answers without wait states
	a_access_ready: assert property (psel && penable |-> pready)
		else $error("access phase not answered");

	// Scenarios worth reaching
	c_window_push: cover property (push ##1 active_flag);
	c_field_switch: cover property (field_start ##[1:400] push);
	c_fifo_full: cover property (pix_valid && !pix_ready);
	c_bad_addr: cover property (pready && pslverr);
	c_frame_dropped: cover property (field_start && field_odd && !frame_next);
endmodule

// [dv/vfw_ctrl_tb.sv]
// Self-checking bench for the video field window controller
`timescale 1ns/1ps
`include "vfw_defines.svh"
module vfw_ctrl_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, v1, v2;
	logic pready, pslverr, pix_ready, win_valid, active_flag;
	logic line_reference = 1'b0, field_reference = 1'b0, field_odd = 1'b0;
	logic std_625 = 1'b1, pix_valid = 1'b0, win_ready = 1'b0;
	logic [15:0] pix_data = 16'h0000;
	logic [15:0] win_data;
	int error_cnt = 0, checks = 0, cnt_pop = 0, cnt_flag = 0;
	int e_first = 17, e_lin = 500, e_lout = 240, e_left = 0, e_width = 640, e_fsel = 0;
	bit e_drop = 1'b0, stall = 1'b0, stall_hit = 1'b0, rnd_idle = 1'b1;

	vfw_ctrl #(.DATA_W(16), .FIFO_DEPTH(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_reference(line_reference),
		.field_reference(field_reference), .field_odd(field_odd), .std_625(std_625),
		.pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
		.win_valid(win_valid), .win_data(win_data), .win_ready(win_ready),
		.active_flag(active_flag));

	// Free-running 25 MHz clock
	initial
	begin
		forever #20 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// A wait that ran out is a failure, not a hang
	task automatic give_up();
		error_cnt++;
		final_report();
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [9:0] idx, input logic [11:0] d,
		input logic eerr, output logic [31:0] r);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {20'h00000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			give_up();
		r = prdata;
		chk("slave_error", pslverr, eerr);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Lines actually used once the field total clamps the range
	function automatic int eff();
		int total = std_625 ? 312 : 262;
		return (e_lin < total - e_first) ? e_lin : total - e_first;
	endfunction

	function automatic bit in_win(logic [15:0] d);
		int ln = int'(d[15:7]);
		int px = int'(d[6:0]);
		return ln >= e_first && ln < e_first + eff() && px >= e_left && px < e_left + e_width;
	endfunction

	task automatic setwin(input int first, input int lin, input int lout, input int left,
		input int width, input logic [2:0] mode);
		logic [31:0] r;
		apb(1'b1, `VFW_IDX_FIRST, first[11:0], 1'b0, r);
		apb(1'b1, `VFW_IDX_LINES_IN, {mode, lin[8:0]}, 1'b0, r);
		apb(1'b1, `VFW_IDX_LINES_OUT, lout[11:0], 1'b0, r);
		apb(1'b1, `VFW_IDX_LEFT, left[11:0], 1'b0, r);
		apb(1'b1, `VFW_IDX_WIDTH, width[11:0], 1'b0, r);
		e_first = first;
		e_lin = lin;
		e_lout = lout;
		e_left = left;
		e_width = width;
		e_fsel = int'(mode[2:1]);
	endtask

	// One active line of 12 pixels tagged with line and pixel number
	task automatic vline(input int ln, input int gap);
		int n;
		line_reference <= 1'b1;
		for (int p = 0; p < 12; p++)
		begin
			if (rnd_idle && $urandom_range(0, 2) == 0)
			begin
				pix_valid <= 1'b0;
				@(posedge pclk);
			end
			pix_valid <= 1'b1;
			pix_data <= {ln[8:0], p[6:0]};
			n = 0;
			do
			begin
				@(posedge pclk);
				n++;
			end
			while (pix_ready !== 1'b1 && n < 200);
			if (pix_ready !== 1'b1)
				give_up();
		end
		pix_valid <= 1'b0;
		line_reference <= 1'b0;
		repeat (gap) @(posedge pclk);
	endtask

	// Whole field, then drain and compare the kept count with the model
	task automatic vfield(input logic odd, input int gap, input bit mid);
		int n = 0;
		int lines, per;
		bit on;
		cnt_pop = 0;
		cnt_flag = 0;
		field_odd <= odd;
		field_reference <= 1'b1;
		repeat (2) @(posedge pclk);
		field_reference <= 1'b0;
		repeat (2) @(posedge pclk);
		for (int ln = 1; ln <= e_first + eff(); ln++)
		begin
			vline(ln, gap);
			if (mid && ln == 3)
				apb(1'b1, `VFW_IDX_LEFT, 12'h000, 1'b0, v2);
		end
		while ((win_valid !== 1'b0 || stall) && n < 300)
		begin
			@(posedge pclk);
			n++;
		end
		if (win_valid !== 1'b0 || stall)
			give_up();
		on = (e_fsel == 0 || (e_fsel == 2 && odd) || (e_fsel == 1 && !odd)) && !e_drop;
		lines = (e_lout < eff()) ? e_lout : eff();
		per = ((e_left + e_width < 12) ? e_left + e_width : 12) - e_left;
		chk("kept_pixels", cnt_pop, on ? lines * per : 0);
		chk("flag_pulses", cnt_flag, cnt_pop);
	endtask

	// Sink: random back-pressure, or a stall until the buffer refuses
	always @(posedge pclk)
	begin
		if (win_valid === 1'b1 && win_ready === 1'b1)
		begin
			cnt_pop++;
			chk("window_pixel", in_win(win_data), 32'h00000001);
		end
		if (active_flag === 1'b1)
			cnt_flag++;
		if (stall)
		begin
			win_ready <= 1'b0;
			if (pix_ready === 1'b0)
			begin
				chk("buffer_full", win_valid, 32'h00000001);
				stall_hit = 1'b1;
				stall = 1'b0;
			end
		end
		else
			win_ready <= ($urandom_range(0, 3) != 0);
	end

	// Main sequence
	initial
	begin
		int lin;
		void'($urandom(32'hc10e9c46));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `VFW_IDX_QUOTA, 12'h000, 1'b0, v1);
		chk("quota_reset", v1, 32'h00000bb8);
		apb(1'b0, 10'h100, 12'h000, 1'b1, v1);
		chk("unmapped_read", v1, 32'h00000000);
		apb(1'b1, `VFW_IDX_FLAG, 12'h000, 1'b1, v1);
		apb(1'b0, `VFW_IDX_WIDTH, 12'h000, 1'b0, v1);
		chk("wo_read", v1, 32'h00000000);
		// Reset window settings, including the clamp of the default range
		vfield(1'b1, 3, 1'b0);
		apb(1'b1, `VFW_IDX_NPIX, 12'h020, 1'b0, v1);
		for (int i = 0; i < 4; i++)
		begin
			lin = $urandom_range(2, 6);
			setwin(7, lin, $urandom_range(1, lin), $urandom_range(0, 5), $urandom_range(1, 6),
				3'b000);
			vfield($urandom_range(0, 1) == 1, 3, 1'b0);
		end
		// Mid-field edit must wait for the next field; buffer forced full meanwhile
		setwin(7, 4, 4, 2, 3, 3'b000);
		stall = 1'b1;
		vfield(1'b0, 3, 1'b1);
		chk("stall_seen", stall_hit, 32'h00000001);
		e_left = 0;
		vfield(1'b1, 3, 1'b0);
		for (int f = 0; f < 8; f++)
		begin
			setwin(7, 3, 3, 1, 4, {f[2:1], 1'b0});
			vfield(f[0], 3, 1'b0);
		end
		// Decimation: zero quota drops the frame, full quota and bit clear keep it
		apb(1'b1, `VFW_IDX_QUOTA, 12'h000, 1'b0, v1);
		setwin(7, 3, 2, 0, 4, 3'b001);
		e_drop = 1'b1;
		vfield(1'b1, 3, 1'b0);
		vfield(1'b0, 3, 1'b0);
		apb(1'b1, `VFW_IDX_QUOTA, 12'hbb8, 1'b0, v1);
		e_drop = 1'b0;
		vfield(1'b1, 3, 1'b0);
		apb(1'b1, `VFW_IDX_QUOTA, 12'h000, 1'b0, v1);
		setwin(7, 3, 2, 0, 4, 3'b000);
		vfield(1'b1, 3, 1'b0);
		for (int s = 0; s < 2; s++)
		begin
			std_625 <= s[0];
			@(posedge pclk);
			setwin(s[0] ? 308 : 258, 10, 10, 1, 3, 3'b000);
			vfield(1'b1, 3, 1'b0);
		end
		// Zero output lines keep nothing of the field
		setwin(7, 3, 0, 0, 4, 3'b000);
		vfield(1'b0, 3, 1'b0);
		// Flag position must grow with the gap after the line falls
		rnd_idle = 1'b0;
		setwin(7, 3, 3, 2, 3, 3'b000);
		vfield(1'b1, 4, 1'b0);
		apb(1'b0, `VFW_IDX_FLAG, 12'h000, 1'b0, v1);
		vfield(1'b1, 9, 1'b0);
		apb(1'b0, `VFW_IDX_FLAG, 12'h000, 1'b0, v2);
		chk("flag_step", v2 - v1, 32'h0000000a);
		chk("flag_spare", {v1[31:12], v1[0]}, 32'h00000000);
		final_report();
	end
endmodule
